// ---- pkg/srq_pkg.sv ----
package srq_pkg;

  // Register byte offsets on the APB side.
  localparam logic [7:0] CMD_OFS    = 8'h00;
  localparam logic [7:0] STATUS_OFS = 8'h04;
  localparam logic [7:0] MASK_OFS   = 8'h08;
  localparam logic [7:0] OUTPUT_OFS = 8'h0c;
  localparam logic [7:0] LOG_OFS    = 8'h10;
  localparam logic [7:0] COUNT_OFS  = 8'h14;

  // Status byte codes returned by serial poll.
  localparam logic [7:0] CODE_NONE    = 8'h00;
  localparam logic [7:0] CODE_SYNTAX  = 8'h61;
  localparam logic [7:0] CODE_RANGE   = 8'h62;
  localparam logic [7:0] CODE_BREAKER = 8'h64;
  localparam logic [7:0] CODE_TO_CC   = 8'h68;
  localparam logic [7:0] CODE_TO_CV   = 8'h58;

  // Command register fields and command codes.
  localparam int         CMD_CODE_LSB = 0;
  localparam int         CMD_CODE_W   = 3;
  localparam int         CMD_CHAN_BIT = 3;
  localparam logic [2:0] CMD_NOP      = 3'h0;
  localparam logic [2:0] CMD_MASK1    = 3'h1;
  localparam logic [2:0] CMD_MASK2    = 3'h2;
  localparam logic [2:0] CMD_MASK3    = 3'h3;
  localparam logic [2:0] CMD_MASK4    = 3'h4;
  localparam logic [2:0] CMD_OUT_ON   = 3'h5;
  localparam logic [2:0] CMD_OUT_OFF  = 3'h6;

  // Status register fields.
  localparam int STAT_CODE_LSB  = 0;
  localparam int STAT_SRQ_BIT   = 8;
  localparam int STAT_LONLY_BIT = 9;
  localparam int STAT_ADDR_LSB  = 10;
  localparam int STAT_CFG_BIT   = 15;

  // Cause log bits; channel B causes sit LOG_CHAN_STRIDE above channel A.
  localparam int LOG_SYNTAX_BIT  = 0;
  localparam int LOG_RANGE_BIT   = 1;
  localparam int LOG_BRK_BIT     = 2;
  localparam int LOG_CC_BIT      = 3;
  localparam int LOG_CV_BIT      = 4;
  localparam int LOG_CHAN_STRIDE = 3;
  localparam int LOG_W           = 8;

  // Reset values.
  localparam logic [1:0] OUT_RESET = 2'b00;

  typedef enum logic [3:0] {
    MASK_ALL   = 4'b0001,
    MASK_REG   = 4'b0010,
    MASK_BRK   = 4'b0100,
    UNMASK_ALL = 4'b1000
  } mask_state_t;

  localparam mask_state_t MASK_RESET = UNMASK_ALL;

endpackage : srq_pkg

// ---- pkg/cause_if.sv ----
`timescale 1ns/1ns
interface cause_if;
  logic                brk_raw;
  logic                cc_raw;
  logic                cv_raw;
  logic                brk_req;
  logic                cc_req;
  logic                cv_req;
  srq_pkg::mask_state_t mask_state;

  modport chan (output brk_raw, cc_raw, cv_raw, brk_req, cc_req, cv_req, mask_state);
  modport ctrl (input brk_raw, cc_raw, cv_raw, brk_req, cc_req, cv_req, mask_state);
endinterface : cause_if

// ---- rtl/sync3.sv ----
`timescale 1ns/1ns
module sync3 #(
  parameter int W = 1
) (
  // Clock and reset
  input  wire logic         sys_clk_i,
  input  wire logic         resetn_i,
  // Asynchronous input and filtered result
  input  wire logic [W-1:0] d_i,
  output logic      [W-1:0] q_o,
  output logic              valid_o
);
  logic [W-1:0] s1_r;
  logic [W-1:0] s2_r;
  logic [W-1:0] s3_r;
  logic [1:0]   fill_r;

  always_ff @(posedge sys_clk_i) begin
    s1_r <= d_i;
    s2_r <= s1_r;
    s3_r <= s2_r;
  end

  // The output moves only when the second and third stages agree.
  always_ff @(posedge sys_clk_i) begin
    if (!resetn_i) begin
      fill_r  <= 2'h0;
      valid_o <= 1'b0;
      q_o     <= '0;
    end else begin
      if (fill_r != 2'h3) begin
        fill_r <= fill_r + 2'h1;
      end
      if (fill_r == 2'h3 && s2_r == s3_r) begin
        q_o     <= s3_r;
        valid_o <= 1'b1;
      end
    end
  end
endmodule : sync3

// ---- rtl/channel_cause.sv ----
`timescale 1ns/1ns
module channel_cause
  import srq_pkg::*;
(
  // Clock and reset
  input  wire logic sys_clk_i,
  input  wire logic resetn_i,
  // Filtered supply status
  input  wire logic stat_valid_i,
  input  wire logic breaker_i,
  input  wire logic cc_mode_i,
  // Mask commands
  input  wire logic mask_wr_i,
  input  wire logic [2:0] mask_cmd_i,
  input  wire logic reinit_i,
  // Causes towards the request logic
  cause_if.chan     cause
);
  logic        primed_r;
  logic        brk_prev_r;
  logic        cc_prev_r;
  mask_state_t mask_r;

  // Edges are only trusted once a first settled sample has been taken.
  always_ff @(posedge sys_clk_i) begin
    if (!resetn_i) begin
      primed_r   <= 1'b0;
      brk_prev_r <= 1'b0;
      cc_prev_r  <= 1'b0;
    end else if (stat_valid_i) begin
      primed_r   <= 1'b1;
      brk_prev_r <= breaker_i;
      cc_prev_r  <= cc_mode_i;
    end
  end

  assign cause.brk_raw = primed_r && breaker_i && !brk_prev_r;
  assign cause.cc_raw  = primed_r && cc_mode_i && !cc_prev_r;
  assign cause.cv_raw  = primed_r && !cc_mode_i && cc_prev_r;

  always_ff @(posedge sys_clk_i) begin
    if (!resetn_i || reinit_i) begin
      mask_r <= MASK_RESET;
    end else if (mask_wr_i) begin
      case (mask_cmd_i)
        CMD_MASK1: mask_r <= MASK_ALL;
        CMD_MASK2: mask_r <= MASK_REG;
        CMD_MASK3: mask_r <= MASK_BRK;
        CMD_MASK4: mask_r <= UNMASK_ALL;
        default:   mask_r <= mask_r;
      endcase
    end
  end

  assign cause.mask_state = mask_r;
  assign cause.brk_req = cause.brk_raw &&
                         (mask_r == MASK_REG || mask_r == UNMASK_ALL);
  assign cause.cc_req  = cause.cc_raw &&
                         (mask_r == MASK_BRK || mask_r == UNMASK_ALL);
  assign cause.cv_req  = cause.cv_raw &&
                         (mask_r == MASK_BRK || mask_r == UNMASK_ALL);
endmodule : channel_cause

// ---- rtl/srq_top.sv ----
// The register addresses and the APB register port were decided locally.
`timescale 1ns/1ns
// Operation
// - Breaker trip raises cause with code 100.
// - Change from voltage to current gives 104.
// - Change from current to voltage gives 88.
// - First mask command blocks all supply causes.
// - Second mask command leaves only breaker requests.
// - Third mask command blocks only breaker requests.
// - Fourth mask command unblocks all supply causes.
// - Addressable: errors and transitions raise requests.
// - Addressable: breaker reinitialises and raises request in the same cycle.
// - Listen-only: command errors reinitialise the device.
// - Listen-only: supply causes are ignored entirely; the cause log still records them.
// - Syntax error gives 97, range error 98.
// - Serial poll returns the pending status byte.
// - Trigger command switches both outputs on together.
module srq_top
  import srq_pkg::*;
(
  // Clock and reset
  input  wire logic        sys_clk_i,
  input  wire logic        resetn_i,
  // APB slave
  input  wire logic        psel_i,
  input  wire logic        penable_i,
  input  wire logic        pwrite_i,
  input  wire logic [7:0]  paddr_i,
  input  wire logic [31:0] pwdata_i,
  output logic      [31:0] prdata_o,
  output logic             pready_o,
  output logic             pslverr_o,
  // Command parser events, same clock
  input  wire logic        syntax_err_i,
  input  wire logic        range_err_i,
  input  wire logic        trigger_i,
  // Bus side
  input  wire logic        serial_poll_i,
  output logic             srq_o,
  output logic      [7:0]  status_byte_o,
  output logic      [4:0]  bus_addr_o,
  output logic             listen_only_o,
  // Configuration switches
  input  wire logic [4:0]  addr_sw_i,
  input  wire logic        listen_only_sw_i,
  // Supply status pins, channel A in bit 0
  input  wire logic [1:0]  breaker_i,
  input  wire logic [1:0]  cc_mode_i,
  // Supply control
  output logic      [1:0]  output_on_o,
  output logic             reinit_o
);
  import srq_pkg::*;

  typedef enum logic [1:0] {
    POLL_IDLE   = 2'b01,
    POLL_ACTIVE = 2'b10
  } poll_state_t;

  logic [3:0]  pin_sync;
  logic        pin_valid;
  logic [5:0]  sw_sync;
  logic        sw_valid;
  logic        poll_sync;
  logic        poll_valid;
  logic        cfg_taken_r;
  logic        lonly_r;
  logic [4:0]  addr_r;
  logic        srq_r;
  logic [7:0]  code_r;
  logic [7:0]  code_nxt;
  logic        take_nxt;
  logic        poll_clear;
  poll_state_t poll_r;
  logic        reinit_nxt;
  logic        reinit_r;
  logic [1:0]  out_r;
  logic [LOG_W-1:0] log_r;
  logic [LOG_W-1:0] log_set;
  logic [7:0]  reinit_cnt_r;
  logic [7:0]  srq_cnt_r;
  logic        setup;
  logic        access;
  logic        wr_cmd;
  logic        wr_log;
  logic        chan_sel;
  logic [2:0]  cmd_code;
  logic [1:0]  mask_wr;
  logic [1:0]  brk_req;
  logic [1:0]  cc_req;
  logic [1:0]  cv_req;
  logic [1:0]  brk_raw;
  logic [1:0]  cc_raw;
  logic [1:0]  cv_raw;
  logic        mapped;
  logic [31:0] rd_mux;
  logic        pready_r;
  logic [31:0] prdata_r;
  logic        pslverr_r;

  cause_if cause_a ();
  cause_if cause_b ();

  // Supply pins, switches and the poll line all come from outside the clock domain.
  sync3 #(.W(4)) u_pin_sync (
    .sys_clk_i (sys_clk_i),
    .resetn_i  (resetn_i),
    .d_i       ({cc_mode_i, breaker_i}),
    .q_o       (pin_sync),
    .valid_o   (pin_valid)
  );

  sync3 #(.W(6)) u_sw_sync (
    .sys_clk_i (sys_clk_i),
    .resetn_i  (resetn_i),
    .d_i       ({listen_only_sw_i, addr_sw_i}),
    .q_o       (sw_sync),
    .valid_o   (sw_valid)
  );

  sync3 #(.W(1)) u_poll_sync (
    .sys_clk_i (sys_clk_i),
    .resetn_i  (resetn_i),
    .d_i       (serial_poll_i),
    .q_o       (poll_sync),
    .valid_o   (poll_valid)
  );

  channel_cause u_chan_a (
    .sys_clk_i    (sys_clk_i),
    .resetn_i     (resetn_i),
    .stat_valid_i (pin_valid),
    .breaker_i    (pin_sync[0]),
    .cc_mode_i    (pin_sync[2]),
    .mask_wr_i    (mask_wr[0]),
    .mask_cmd_i   (cmd_code),
    .reinit_i     (reinit_r),
    .cause        (cause_a)
  );

  channel_cause u_chan_b (
    .sys_clk_i    (sys_clk_i),
    .resetn_i     (resetn_i),
    .stat_valid_i (pin_valid),
    .breaker_i    (pin_sync[1]),
    .cc_mode_i    (pin_sync[3]),
    .mask_wr_i    (mask_wr[1]),
    .mask_cmd_i   (cmd_code),
    .reinit_i     (reinit_r),
    .cause        (cause_b)
  );

  assign brk_req = {cause_b.brk_req, cause_a.brk_req};
  assign cc_req  = {cause_b.cc_req, cause_a.cc_req};
  assign cv_req  = {cause_b.cv_req, cause_a.cv_req};
  assign brk_raw = {cause_b.brk_raw, cause_a.brk_raw};
  assign cc_raw  = {cause_b.cc_raw, cause_a.cc_raw};
  assign cv_raw  = {cause_b.cv_raw, cause_a.cv_raw};

  // Switches are read once, the first time they settle after reset, and never again.
  always_ff @(posedge sys_clk_i) begin
    if (!resetn_i) begin
      cfg_taken_r <= 1'b0;
      lonly_r     <= 1'b0;
      addr_r      <= 5'h00;
    end else if (!cfg_taken_r && sw_valid) begin
      cfg_taken_r <= 1'b1;
      addr_r      <= sw_sync[4:0];
      lonly_r     <= sw_sync[5];
    end
  end

  // APB: one wait-free access phase; pready is registered so every output is a flop.
  assign setup    = psel_i && !penable_i;
  assign access   = psel_i && penable_i && pready_r;
  assign chan_sel = pwdata_i[CMD_CHAN_BIT];
  assign cmd_code = pwdata_i[CMD_CODE_LSB +: CMD_CODE_W];
  assign wr_cmd   = access && pwrite_i && paddr_i == CMD_OFS;
  assign wr_log   = access && pwrite_i && paddr_i == LOG_OFS;
  assign mask_wr  = wr_cmd ? {chan_sel, !chan_sel} : 2'b00;

  always_comb begin
    mapped = 1'b1;
    rd_mux = 32'h0000_0000;
    case (paddr_i)
      CMD_OFS:    rd_mux = 32'h0000_0000;
      STATUS_OFS: begin
        rd_mux[STAT_CODE_LSB +: 8] = code_r;
        rd_mux[STAT_SRQ_BIT]       = srq_r;
        rd_mux[STAT_LONLY_BIT]     = lonly_r;
        rd_mux[STAT_ADDR_LSB +: 5] = addr_r;
        rd_mux[STAT_CFG_BIT]       = cfg_taken_r;
      end
      MASK_OFS:   rd_mux[7:0] = {cause_b.mask_state, cause_a.mask_state};
      OUTPUT_OFS: rd_mux[1:0] = out_r;
      LOG_OFS:    rd_mux[LOG_W-1:0] = log_r;
      COUNT_OFS:  rd_mux[15:0] = {srq_cnt_r, reinit_cnt_r};
      default:    mapped = 1'b0;
    endcase
  end

  always_ff @(posedge sys_clk_i) begin
    if (!resetn_i) begin
      pready_r  <= 1'b0;
      prdata_r  <= 32'h0000_0000;
      pslverr_r <= 1'b0;
    end else begin
      pready_r  <= setup;
      if (setup) begin
        prdata_r  <= pwrite_i ? 32'h0000_0000 : rd_mux;
        pslverr_r <= !mapped;
      end else if (access) begin
        prdata_r  <= 32'h0000_0000;
        pslverr_r <= 1'b0;
      end
    end
  end

  // Reinitialisation sources depend on the mode taken from the switches.
  always_comb begin
    if (lonly_r) begin
      reinit_nxt = syntax_err_i || range_err_i;
    end else begin
      reinit_nxt = |brk_raw;
    end
  end

  always_ff @(posedge sys_clk_i) begin
    if (!resetn_i) begin
      reinit_r <= 1'b0;
    end else begin
      reinit_r <= reinit_nxt;
    end
  end

  // Output switches; reinit wins over a trigger in the same cycle for safety.
  always_ff @(posedge sys_clk_i) begin
    if (!resetn_i || reinit_r) begin
      out_r <= OUT_RESET;
    end else if (trigger_i) begin
      out_r <= 2'b11;
    end else if (wr_cmd && cmd_code == CMD_OUT_ON) begin
      out_r[chan_sel] <= 1'b1;
    end else if (wr_cmd && cmd_code == CMD_OUT_OFF) begin
      out_r[chan_sel] <= 1'b0;
    end
  end

  // Serial poll: the byte stands while the poll lasts and clears at its end.
  always_ff @(posedge sys_clk_i) begin
    if (!resetn_i) begin
      poll_r <= POLL_IDLE;
    end else begin
      case (poll_r)
        POLL_IDLE:   if (poll_valid && poll_sync) poll_r <= POLL_ACTIVE;
        POLL_ACTIVE: if (!poll_sync) poll_r <= POLL_IDLE;
        default:     poll_r <= POLL_IDLE;
      endcase
    end
  end

  assign poll_clear = poll_r == POLL_ACTIVE && !poll_sync;

  // Pick the highest-priority unmasked cause; only a free slot may take one.
  always_comb begin
    take_nxt = 1'b0;
    code_nxt = CODE_NONE;
    if (!srq_r || poll_clear) begin
      if (!lonly_r) begin
        if (syntax_err_i) begin
          take_nxt = 1'b1;
          code_nxt = CODE_SYNTAX;
        end else if (range_err_i) begin
          take_nxt = 1'b1;
          code_nxt = CODE_RANGE;
        end else if (|brk_req) begin
          take_nxt = 1'b1;
          code_nxt = CODE_BREAKER;
        end else if (|cc_req) begin
          take_nxt = 1'b1;
          code_nxt = CODE_TO_CC;
        end else if (|cv_req) begin
          take_nxt = 1'b1;
          code_nxt = CODE_TO_CV;
        end
      end
    end
  end

  // A new cause in the poll-clear cycle is kept, so the clear does not lose it.
  always_ff @(posedge sys_clk_i) begin
    if (!resetn_i) begin
      srq_r  <= 1'b0;
      code_r <= CODE_NONE;
    end else if (take_nxt) begin
      srq_r  <= 1'b1;
      code_r <= code_nxt;
    end else if (poll_clear) begin
      srq_r  <= 1'b0;
      code_r <= CODE_NONE;
    end
  end

  // Raw cause log for software, write one to clear, set wins.
  always_comb begin
    log_set = '0;
    log_set[LOG_SYNTAX_BIT] = syntax_err_i;
    log_set[LOG_RANGE_BIT]  = range_err_i;
    for (int c = 0; c < 2; c++) begin
      log_set[LOG_BRK_BIT + c * LOG_CHAN_STRIDE] = brk_raw[c];
      log_set[LOG_CC_BIT + c * LOG_CHAN_STRIDE]  = cc_raw[c];
      log_set[LOG_CV_BIT + c * LOG_CHAN_STRIDE]  = cv_raw[c];
    end
  end

  always_ff @(posedge sys_clk_i) begin
    if (!resetn_i) begin
      log_r <= '0;
    end else begin
      log_r <= (log_r & ~(wr_log ? pwdata_i[LOG_W-1:0] : '0)) | log_set;
    end
  end

  // Saturating activity counters.
  always_ff @(posedge sys_clk_i) begin
    if (!resetn_i) begin
      reinit_cnt_r <= 8'h00;
      srq_cnt_r    <= 8'h00;
    end else begin
      if (reinit_r && reinit_cnt_r != 8'hff) begin
        reinit_cnt_r <= reinit_cnt_r + 8'h01;
      end
      if (take_nxt && srq_cnt_r != 8'hff) begin
        srq_cnt_r <= srq_cnt_r + 8'h01;
      end
    end
  end

  assign prdata_o      = prdata_r;
  assign pready_o      = pready_r;
  assign pslverr_o     = pslverr_r;
  assign srq_o         = srq_r;
  assign status_byte_o = code_r;
  assign bus_addr_o    = addr_r;
  assign listen_only_o = lonly_r;
  assign output_on_o   = out_r;
  assign reinit_o      = reinit_r;
endmodule : srq_top

// ---- dv/srq_top_assertions.sv ----
`timescale 1ns/1ns
module srq_top_assertions
  import srq_pkg::*;
(
  // Clock and reset
  input wire logic       sys_clk_i,
  input wire logic       resetn_i,
  // Causes and poll
  input wire logic       syntax_err_i,
  input wire logic       range_err_i,
  input wire logic       trigger_i,
  input wire logic       serial_poll_i,
  // Observed outputs
  input wire logic       srq_o,
  input wire logic [7:0] status_byte_o,
  input wire logic [4:0] bus_addr_o,
  input wire logic       listen_only_o,
  input wire logic [1:0] output_on_o,
  input wire logic       reinit_o
);
  default clocking cb @(posedge sys_clk_i);
  endclocking
  default disable iff (!resetn_i);

  // Cycles since reset release; the switches are captured well inside ten.
  logic [3:0] up_cnt_r;
  always_ff @(posedge sys_clk_i) begin
    if (!resetn_i) begin
      up_cnt_r <= 4'h0;
    end else if (up_cnt_r != 4'hf) begin
      up_cnt_r <= up_cnt_r + 4'h1;
    end
  end

  switch_latch_a: assert property (
    up_cnt_r >= 4'ha |-> $stable(bus_addr_o) && $stable(listen_only_o))
    else $error("switch settings changed after capture");
  syntax_code_a: assert property (
    syntax_err_i && !srq_o && !listen_only_o |=> srq_o && status_byte_o == CODE_SYNTAX)
    else $error("syntax error did not raise its request");
  range_code_a: assert property (
    range_err_i && !syntax_err_i && !srq_o && !listen_only_o |=> status_byte_o == CODE_RANGE)
    else $error("range error did not give its code");
  // Only a poll that has stood for four samples is certain to have passed the filter.
  srq_hold_a: assert property (
    srq_o && serial_poll_i && $past(serial_poll_i) && $past(serial_poll_i, 3) |=> srq_o)
    else $error("request dropped during poll");
  poll_clear_a: assert property (
    srq_o && $fell(serial_poll_i) |-> ##[1:6] !srq_o)
    else $error("request not cleared after poll");
  status_hold_a: assert property (
    srq_o && $past(srq_o) |-> $stable(status_byte_o))
    else $error("pending status byte overwritten");
  idle_status_a: assert property (
    !srq_o |-> status_byte_o == CODE_NONE)
    else $error("status byte not clear without request");
  lonly_quiet_a: assert property (
    listen_only_o |-> !srq_o)
    else $error("request raised in listen-only mode");
  lonly_reinit_a: assert property (
    listen_only_o && (syntax_err_i || range_err_i) |-> ##[1:2] reinit_o)
    else $error("command error did not reinitialise");
  trigger_on_a: assert property (
    trigger_i && !reinit_o |=> output_on_o == 2'b11)
    else $error("trigger did not switch both outputs on");
  reinit_off_a: assert property (
    reinit_o && !trigger_i |-> ##[0:1] output_on_o == 2'b00)
    else $error("outputs left on after reinitialisation");
endmodule : srq_top_assertions

bind srq_top srq_top_assertions u_chk (
  .sys_clk_i, .resetn_i, .syntax_err_i, .range_err_i, .trigger_i, .serial_poll_i,
  .srq_o, .status_byte_o, .bus_addr_o, .listen_only_o, .output_on_o, .reinit_o
);

// ---- dv/far_side_model.sv ----
`timescale 1ns/1ns
module far_side_model (
  // Clock
  input  wire logic       sys_clk_i,
  // Request and status byte from the block
  input  wire logic       srq_i,
  input  wire logic [7:0] status_byte_i,
  output logic            serial_poll_o,
  // Supply status lines, channel A in bit 0
  output logic      [1:0] breaker_o,
  output logic      [1:0] cc_mode_o
);
  initial begin
    serial_poll_o = 1'b0;
    breaker_o     = 2'b00;
    cc_mode_o     = 2'b00;
  end

  // The controller polls only while a request stands and holds the poll long enough
  // for the block's input filter to settle before it reads the byte.
  task automatic poll(output logic [7:0] code);
    code = 8'h00;
    if (srq_i === 1'b1) begin
      @(posedge sys_clk_i);
      serial_poll_o <= 1'b1;
      repeat (6) @(posedge sys_clk_i);
      code = status_byte_i;
      serial_poll_o <= 1'b0;
    end
  endtask : poll

  task automatic set_pins(input int ch, input logic brk, input logic cc);
    @(posedge sys_clk_i);
    breaker_o[ch] <= brk;
    cc_mode_o[ch] <= cc;
  endtask : set_pins
endmodule : far_side_model

// ---- dv/service_request_cause_masking_test.sv ----
`timescale 1ns/1ns
module service_request_cause_masking_test;
  import srq_pkg::*;
  logic        sys_clk_i, resetn_i, psel_i, penable_i, pwrite_i, pready_o, pslverr_o;
  logic [7:0]  paddr_i, status_byte_o;
  logic [31:0] pwdata_i, prdata_o, rdat;
  logic        syntax_err_i, range_err_i, trigger_i, serial_poll_i, srq_o, listen_only_o;
  logic [4:0]  addr_sw_i, bus_addr_o;
  logic        listen_only_sw_i, reinit_o, rerr, seen;
  logic [1:0]  breaker_i, cc_mode_i, output_on_o;
  int          fails, checked;

  srq_top u_dut (
    .sys_clk_i, .resetn_i, .psel_i, .penable_i, .pwrite_i, .paddr_i, .pwdata_i, .prdata_o,
    .pready_o, .pslverr_o, .syntax_err_i, .range_err_i, .trigger_i, .serial_poll_i, .srq_o,
    .status_byte_o, .bus_addr_o, .listen_only_o, .addr_sw_i, .listen_only_sw_i, .breaker_i,
    .cc_mode_i, .output_on_o, .reinit_o
  );
  far_side_model u_far (
    .sys_clk_i, .srq_i(srq_o), .status_byte_i(status_byte_o), .serial_poll_o(serial_poll_i),
    .breaker_o(breaker_i), .cc_mode_o(cc_mode_i)
  );

  initial begin
    sys_clk_i = 1'b0;
    forever #2 sys_clk_i = ~sys_clk_i;
  end

  task automatic stop_test();
    $display("fails=%0d checked=%0d", fails, checked);
    if (fails == 0 && checked > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask : stop_test

  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      fails++;
      $display("mismatch at %0t got %h expected %h", $time, got, exp);
    end
  endtask : check

  // One APB transfer; the request holds until pready is seen high at an edge.
  task automatic apb(input logic wr, input logic [7:0] addr, input logic [31:0] wd);
    int n;
    @(posedge sys_clk_i);
    psel_i   <= 1'b1;
    pwrite_i <= wr;
    paddr_i  <= addr;
    pwdata_i <= wd;
    @(posedge sys_clk_i);
    penable_i <= 1'b1;
    n = 0;
    do begin
      @(posedge sys_clk_i);
      n++;
    end while (pready_o !== 1'b1 && n < 20);
    rdat = prdata_o;
    rerr = pslverr_o;
    psel_i    <= 1'b0;
    penable_i <= 1'b0;
    if (n >= 20) begin
      fails++;
      stop_test();
    end
  endtask : apb

  // Kind 0 is a syntax error, 1 a range error, 2 the trigger.
  task automatic pulse(input int kind);
    @(posedge sys_clk_i);
    syntax_err_i <= (kind == 0);
    range_err_i  <= (kind == 1);
    trigger_i    <= (kind == 2);
    @(posedge sys_clk_i);
    syntax_err_i <= 1'b0;
    range_err_i  <= 1'b0;
    trigger_i    <= 1'b0;
  endtask : pulse

  // Supply edges pass a filter of a few cycles, so twelve cycles decide a silent cause.
  task automatic expect_srq(input logic [7:0] exp);
    logic [7:0] got;
    int         n;
    n = 0;
    while (srq_o !== 1'b1 && n < 12) begin
      @(posedge sys_clk_i);
      n++;
    end
    check({31'h0, srq_o}, {31'h0, exp != CODE_NONE});
    if (exp != CODE_NONE) begin
      u_far.poll(got);
      check({24'h0, got}, {24'h0, exp});
      repeat (8) @(posedge sys_clk_i);
      check({31'h0, srq_o}, 32'h0);
    end
  endtask : expect_srq

  task automatic do_reset(input logic [4:0] addr, input logic lonly);
    @(posedge sys_clk_i);
    resetn_i         <= 1'b0;
    addr_sw_i        <= addr;
    listen_only_sw_i <= lonly;
    repeat (16) @(posedge sys_clk_i);
    resetn_i <= 1'b1;
    repeat (12) @(posedge sys_clk_i);
    apb(1'b0, STATUS_OFS, 32'h0);
    check(rdat, {16'h0, 1'b1, addr, lonly, 9'h0});
    check({27'h0, bus_addr_o}, {27'h0, addr});
    check({31'h0, listen_only_o}, {31'h0, lonly});
  endtask : do_reset

  initial begin
    fails = 0;
    checked = 0;
    {resetn_i, psel_i, penable_i, pwrite_i, syntax_err_i, range_err_i, trigger_i} = 7'h0;
    paddr_i = 8'h00;
    pwdata_i = 32'h0;
    addr_sw_i = 5'h15;
    listen_only_sw_i = 1'b0;
    do_reset(5'h15, 1'b0);
    addr_sw_i <= 5'h0a;
    listen_only_sw_i <= 1'b1;
    apb(1'b0, STATUS_OFS, 32'h0);
    check(rdat, 32'hd400);
    apb(1'b0, 8'h18, 32'h0);
    check({31'h0, rerr}, 32'h1);
    apb(1'b0, MASK_OFS, 32'h0);
    check(rdat, 32'h88);
    apb(1'b1, CMD_OFS, {28'h0, 1'b1, CMD_OUT_ON});
    apb(1'b0, OUTPUT_OFS, 32'h0);
    check(rdat, 32'h2);
    check({30'h0, output_on_o}, 32'h2);
    apb(1'b1, CMD_OFS, {28'h0, 1'b1, CMD_OUT_OFF});
    apb(1'b0, OUTPUT_OFS, 32'h0);
    check(rdat, 32'h0);
    // The second cause arrives while the first is pending and must be dropped.
    for (int k = 0; k < 2; k++) begin
      pulse(k);
      pulse(1 - k);
      expect_srq(k == 0 ? CODE_SYNTAX : CODE_RANGE);
    end
    // The log keeps raw causes, dropped ones included; a written one clears its bit.
    apb(1'b0, LOG_OFS, 32'h0);
    check(rdat, 32'h3);
    apb(1'b1, LOG_OFS, 32'h3);
    apb(1'b0, LOG_OFS, 32'h0);
    check(rdat, 32'h0);
    apb(1'b0, COUNT_OFS, 32'h0);
    check(rdat, 32'h200);
    for (int ch = 0; ch < 2; ch++) begin
      for (int m = 1; m <= 4; m++) begin
        apb(1'b1, CMD_OFS, {28'h0, ch[0], m[2:0]});
        apb(1'b0, MASK_OFS, 32'h0);
        check((rdat >> (4 * ch)) & 32'hf, 32'h1 << (m - 1));
        u_far.set_pins(ch, 1'b0, 1'b1);
        expect_srq(m >= 3 ? CODE_TO_CC : CODE_NONE);
        u_far.set_pins(ch, 1'b0, 1'b0);
        expect_srq(m >= 3 ? CODE_TO_CV : CODE_NONE);
        pulse(2);
        repeat (2) @(posedge sys_clk_i);
        check({30'h0, output_on_o}, 32'h3);
        u_far.set_pins(ch, 1'b1, 1'b0);
        expect_srq(m[0] ? CODE_NONE : CODE_BREAKER);
        check({30'h0, output_on_o}, 32'h0);
        apb(1'b0, MASK_OFS, 32'h0);
        check(rdat, 32'h88);
        u_far.set_pins(ch, 1'b0, 1'b0);
        repeat (8) @(posedge sys_clk_i);
      end
    end
    do_reset(5'h03, 1'b1);
    pulse(2);
    for (int k = 0; k < 2; k++) begin
      pulse(k);
      seen = 1'b0;
      repeat (4) begin
        @(posedge sys_clk_i);
        seen = seen | (reinit_o === 1'b1);
      end
      check({31'h0, seen}, 32'h1);
      check({30'h0, output_on_o}, 32'h0);
      expect_srq(CODE_NONE);
    end
    pulse(2);
    u_far.set_pins(0, 1'b1, 1'b1);
    expect_srq(CODE_NONE);
    check({30'h0, output_on_o}, 32'h3);
    stop_test();
  end
endmodule : service_request_cause_masking_test
